// File: design/ppfs_defs.svh
// Constants for the port pin function select block.
// Assumes inclusion by bare name from the design files.
`ifndef PPFS_DEFS_SVH
`define PPFS_DEFS_SVH

// ----------------------------------------------------------------
// Pin vector layout
// ----------------------------------------------------------------
`define PPFS_NPINS        18
`define PPFS_P1_BASE      0
`define PPFS_P2_BASE      8
`define PPFS_P3_BASE      16

// ----------------------------------------------------------------
// Special pin positions within their port
// ----------------------------------------------------------------
`define PPFS_P1_INPUT_BIT 5
`define PPFS_MOSI_BIT     2
`define PPFS_MISO_BIT     3
`define PPFS_SS_BIT       4
`define PPFS_SCLK_BIT     5
`define PPFS_XOUT_BIT     0
`define PPFS_XIN_BIT      1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPFS_RST_OE       1'b0
`define PPFS_RST_PU       1'b0
`define PPFS_RST_OUT      1'b1
`define PPFS_RST_SS_N     1'b1

`endif

// File: design/ppfs_pkg.sv
// Types shared by the port pin function select block.
// Assumes nothing beyond a SystemVerilog compiler.
package ppfs_pkg;

  // ----------------------------------------------------------------
  // Port output types, in software encoding order
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPFS_QUASI_BIDIR,
    PPFS_PUSH_PULL,
    PPFS_INPUT_ONLY,
    PPFS_OPEN_DRAIN
  } ppfs_mode_t;

  // ----------------------------------------------------------------
  // CPU clock sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPFS_SRC_RC,
    PPFS_SRC_WDT,
    PPFS_SRC_EXT,
    PPFS_SRC_XTAL
  } ppfs_clk_src_t;

endpackage : ppfs_pkg

// File: design/ppfs_pin_cell.sv
// One port pin: output type decode with alternate function override.
// Assumes a registered consumer; this cell is purely combinational.
`timescale 1ns/10ps
module ppfs_pin_cell
  import ppfs_pkg::*;
(
  // Configuration
  input  wire ppfs_pkg::ppfs_mode_t mode,
  input  wire logic                 latch,
  // Alternate function
  input  wire logic                 alt_en,
  input  wire logic                 alt_out,
  input  wire logic                 alt_drive,
  input  wire logic                 force_in,
  // Pad controls
  output logic                      pad_out,
  output logic                      pad_oe,
  output logic                      pad_pu
);

  import ppfs_pkg::*;

  always_comb begin
    pad_out = latch;
    pad_oe  = 1'b0;
    pad_pu  = 1'b0;
    if (force_in) begin
      pad_out = 1'b0;
    end else if (alt_en) begin
      // Peripheral drive is push-pull whatever the port type says
      pad_out = alt_out;
      pad_oe  = alt_drive;
    end else begin
      case (mode)
        PPFS_QUASI_BIDIR: begin
          pad_oe = ~latch;
          pad_pu = 1'b1;
        end
        PPFS_PUSH_PULL: begin
          pad_oe = 1'b1;
        end
        PPFS_INPUT_ONLY: begin
          pad_oe = 1'b0;
        end
        PPFS_OPEN_DRAIN: begin
          pad_oe = ~latch;
        end
        default: begin
          pad_oe = 1'b0;
        end
      endcase
    end
  end

endmodule : ppfs_pin_cell

// File: design/ppfs_pin_mux.sv
// Pin function selection for ports 1, 2 and 3 of a small controller.
// Assumes all inputs are synchronous to clk (the CPU clock).
`timescale 1ns/10ps
`include "ppfs_defs.svh"

module ppfs_pin_mux
  import ppfs_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Port configuration and latches
  input  wire ppfs_pkg::ppfs_mode_t [7:0]    port1_mode,
  input  wire ppfs_pkg::ppfs_mode_t [7:0]    port2_mode,
  input  wire ppfs_pkg::ppfs_mode_t [1:0]    port3_mode,
  input  wire logic [7:0]                    port1_latch,
  input  wire logic [7:0]                    port2_latch,
  input  wire logic [1:0]                    port3_latch,
  // SPI unit
  input  wire logic                          spi_enable,
  input  wire logic                          spi_master,
  input  wire logic                          spi_mosi_out,
  input  wire logic                          spi_miso_out,
  input  wire logic                          spi_sclk_out,
  // Clock configuration
  input  wire ppfs_pkg::ppfs_clk_src_t       cpu_clk_src,
  input  wire logic                          rtc_uses_crystal,
  input  wire logic                          crystal_option,
  input  wire logic                          clock_out_enable,
  // Pad inputs
  input  wire logic [7:0]                    port1_pin_in,
  input  wire logic [7:0]                    port2_pin_in,
  input  wire logic [1:0]                    port3_pin_in,
  // Pad controls
  output logic [7:0]                         port1_out,
  output logic [7:0]                         port1_oe,
  output logic [7:0]                         port1_pu,
  output logic [7:0]                         port2_out,
  output logic [7:0]                         port2_oe,
  output logic [7:0]                         port2_pu,
  output logic [1:0]                         port3_out,
  output logic [1:0]                         port3_oe,
  output logic [1:0]                         port3_pu,
  // Core side
  output logic [7:0]                         port1_core_in,
  output logic [7:0]                         port2_core_in,
  output logic [1:0]                         port3_core_in,
  output logic                               spi_ss_n,
  output logic                               osc_amp_connect,
  output logic                               osc_in_connect,
  output logic                               half_clock_active
);

  import ppfs_pkg::*;

  // ----------------------------------------------------------------
  // Flattened pin vectors
  // ----------------------------------------------------------------
  logic [`PPFS_NPINS-1:0][1:0]  mode_v;
  logic [`PPFS_NPINS-1:0]       latch_v;
  logic [`PPFS_NPINS-1:0]       pin_in_v;
  logic [`PPFS_NPINS-1:0]       alt_en;
  logic [`PPFS_NPINS-1:0]       alt_out;
  logic [`PPFS_NPINS-1:0]       alt_drive;
  logic [`PPFS_NPINS-1:0]       force_in;
  logic [`PPFS_NPINS-1:0]       cell_out;
  logic [`PPFS_NPINS-1:0]       cell_oe;
  logic [`PPFS_NPINS-1:0]       cell_pu;

  assign mode_v   = {port3_mode, port2_mode, port1_mode};
  assign latch_v  = {port3_latch, port2_latch, port1_latch};
  assign pin_in_v = {port3_pin_in, port2_pin_in, port1_pin_in};

  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  logic [`PPFS_NPINS-1:0] out_r,  out_nxt;
  logic [`PPFS_NPINS-1:0] oe_r,   oe_nxt;
  logic [`PPFS_NPINS-1:0] pu_r,   pu_nxt;
  logic [`PPFS_NPINS-1:0] in_r,   in_nxt;
  logic                   ss_n_r, ss_n_nxt;
  logic                   half_r, half_nxt;
  logic                   amp_r,  amp_nxt;
  logic                   osc_r,  osc_nxt;
  logic                   ck_on_r, ck_on_nxt;

  logic spi_slave;
  logic xin_port_ok;
  logic ck_allowed;

  // ----------------------------------------------------------------
  // Function selection
  // ----------------------------------------------------------------
  always_comb begin
    spi_slave   = spi_enable && !spi_master;
    xin_port_ok = (cpu_clk_src == PPFS_SRC_RC || cpu_clk_src == PPFS_SRC_WDT) && !rtc_uses_crystal;
    // Crystal option wins the pin, so the divided clock yields to it
    ck_allowed  = (cpu_clk_src != PPFS_SRC_XTAL) && !rtc_uses_crystal && !crystal_option;
    ck_on_nxt   = clock_out_enable && ck_allowed;
    half_nxt    = ck_on_nxt ? ~half_r : 1'b0;
    amp_nxt     = crystal_option;
    osc_nxt     = !xin_port_ok;
    alt_en      = '0;
    alt_out     = '0;
    alt_drive   = '0;
    force_in    = '0;
    force_in[`PPFS_P1_BASE + `PPFS_P1_INPUT_BIT] = 1'b1;
    if (spi_enable) begin
      alt_en[`PPFS_P2_BASE + `PPFS_MOSI_BIT]    = 1'b1;
      alt_out[`PPFS_P2_BASE + `PPFS_MOSI_BIT]   = spi_mosi_out;
      alt_drive[`PPFS_P2_BASE + `PPFS_MOSI_BIT] = spi_master;
      alt_en[`PPFS_P2_BASE + `PPFS_MISO_BIT]    = 1'b1;
      alt_out[`PPFS_P2_BASE + `PPFS_MISO_BIT]   = spi_miso_out;
      alt_drive[`PPFS_P2_BASE + `PPFS_MISO_BIT] = !spi_master;
      alt_en[`PPFS_P2_BASE + `PPFS_SCLK_BIT]    = 1'b1;
      alt_out[`PPFS_P2_BASE + `PPFS_SCLK_BIT]   = spi_sclk_out;
      alt_drive[`PPFS_P2_BASE + `PPFS_SCLK_BIT] = spi_master;
    end
    if (spi_slave) begin
      alt_en[`PPFS_P2_BASE + `PPFS_SS_BIT]      = 1'b1;
    end
    if (crystal_option) begin
      force_in[`PPFS_P3_BASE + `PPFS_XOUT_BIT]  = 1'b1;
    end else if (ck_on_nxt) begin
      alt_en[`PPFS_P3_BASE + `PPFS_XOUT_BIT]    = 1'b1;
      alt_out[`PPFS_P3_BASE + `PPFS_XOUT_BIT]   = half_nxt;
      alt_drive[`PPFS_P3_BASE + `PPFS_XOUT_BIT] = 1'b1;
    end
    if (!xin_port_ok) begin
      force_in[`PPFS_P3_BASE + `PPFS_XIN_BIT]   = 1'b1;
    end
    out_nxt  = cell_out;
    oe_nxt   = cell_oe;
    pu_nxt   = cell_pu;
    in_nxt   = pin_in_v;
    ss_n_nxt = spi_slave ? pin_in_v[`PPFS_P2_BASE + `PPFS_SS_BIT] : `PPFS_RST_SS_N;
  end

  // ----------------------------------------------------------------
  // Per-pin output type decode
  // ----------------------------------------------------------------
  // Each cell sees only its own mode, latch and alternate function controls, so pins never interact
  for (genvar i = 0; i < `PPFS_NPINS; i++) begin : g_pin
    ppfs_pin_cell u_cell (
      .mode      (ppfs_mode_t'(mode_v[i])),
      .latch     (latch_v[i]),
      .alt_en    (alt_en[i]),
      .alt_out   (alt_out[i]),
      .alt_drive (alt_drive[i]),
      .force_in  (force_in[i]),
      .pad_out   (cell_out[i]),
      .pad_oe    (cell_oe[i]),
      .pad_pu    (cell_pu[i])
    );
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      out_r   <= {`PPFS_NPINS{`PPFS_RST_OUT}};
      oe_r    <= {`PPFS_NPINS{`PPFS_RST_OE}};
      pu_r    <= {`PPFS_NPINS{`PPFS_RST_PU}};
      in_r    <= '0;
      ss_n_r  <= `PPFS_RST_SS_N;
      half_r  <= 1'b0;
      amp_r   <= 1'b0;
      osc_r   <= 1'b0;
      ck_on_r <= 1'b0;
    end else begin
      out_r   <= out_nxt;
      oe_r    <= oe_nxt;
      pu_r    <= pu_nxt;
      in_r    <= in_nxt;
      ss_n_r  <= ss_n_nxt;
      half_r  <= half_nxt;
      amp_r   <= amp_nxt;
      osc_r   <= osc_nxt;
      ck_on_r <= ck_on_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign port1_out       = out_r[`PPFS_P1_BASE +: 8];
  assign port1_oe        = oe_r[`PPFS_P1_BASE +: 8];
  assign port1_pu        = pu_r[`PPFS_P1_BASE +: 8];
  assign port2_out       = out_r[`PPFS_P2_BASE +: 8];
  assign port2_oe        = oe_r[`PPFS_P2_BASE +: 8];
  assign port2_pu        = pu_r[`PPFS_P2_BASE +: 8];
  assign port3_out       = out_r[`PPFS_P3_BASE +: 2];
  assign port3_oe        = oe_r[`PPFS_P3_BASE +: 2];
  assign port3_pu        = pu_r[`PPFS_P3_BASE +: 2];
  assign port1_core_in   = in_r[`PPFS_P1_BASE +: 8];
  assign port2_core_in   = in_r[`PPFS_P2_BASE +: 8];
  assign port3_core_in   = in_r[`PPFS_P3_BASE +: 2];
  assign spi_ss_n        = ss_n_r;
  assign osc_amp_connect = amp_r;
  assign osc_in_connect  = osc_r;
  assign half_clock_active = ck_on_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_clk_run;
    ck_on_r ##1 ck_on_r;
  endsequence

  sequence s_slave_role;
    spi_enable && !spi_master;
  endsequence

  a_miso_direction: assert property (spi_enable |=> port2_oe[`PPFS_MISO_BIT] == !$past(spi_master))
    else $error("data-in-slave-out pin direction wrong for role");
  a_sclk_direction: assert property (spi_enable |=> port2_oe[`PPFS_SCLK_BIT] == $past(spi_master))
    else $error("serial clock pin direction wrong for role");
  a_mosi_direction: assert property (spi_enable |=> port2_oe[`PPFS_MOSI_BIT] == $past(spi_master))
    else $error("data-out pin direction wrong for role");
  a_reset_port3: assert property (disable iff (1'b0) rst |=> port3_oe == 2'h0 && port3_pu == 2'h0)
    else $error("port 3 not input only after reset");
  a_reset_port2: assert property (disable iff (1'b0) rst |=> port2_oe == 8'h00 && port2_pu == 8'h00)
    else $error("port 2 not input only after reset");
  a_port3_independent: assert property (
    (!$past(rst) && !$past(rst, 2)
      && $past({port3_mode[1], port3_latch[1], cpu_clk_src, rtc_uses_crystal})
      == $past({port3_mode[1], port3_latch[1], cpu_clk_src, rtc_uses_crystal}, 2))
    |-> $stable({port3_oe[1], port3_out[1], port3_pu[1]}))
    else $error("port 3 bit 1 changed without its own configuration");
  a_half_clock_toggle: assert property (s_clk_run |-> port3_out[0] != $past(port3_out[0]) && port3_oe[0])
    else $error("clock output not toggling at half rate");
  a_half_clock_gate: assert property (
    (cpu_clk_src == PPFS_SRC_XTAL || rtc_uses_crystal || crystal_option || !clock_out_enable)
    |=> !half_clock_active)
    else $error("clock output enabled for a forbidden source");
  a_xin_release: assert property (
    (cpu_clk_src == PPFS_SRC_EXT || cpu_clk_src == PPFS_SRC_XTAL || rtc_uses_crystal)
    |=> osc_in_connect && !port3_oe[1] && !port3_pu[1])
    else $error("crystal input released while oscillator needs it");
  a_xout_amp: assert property (crystal_option |=> osc_amp_connect && !port3_oe[0] && !port3_pu[0])
    else $error("crystal output not held by amplifier");
  a_xout_port: assert property (!crystal_option |=> !osc_amp_connect)
    else $error("amplifier joined without crystal option");
  a_p1_input_only: assert property (!port1_oe[`PPFS_P1_INPUT_BIT] && !port1_pu[`PPFS_P1_INPUT_BIT])
    else $error("port 1 bit 5 driven");
  a_slave_select: assert property (s_slave_role |=> spi_ss_n == $past(port2_pin_in[`PPFS_SS_BIT]) && !port2_oe[`PPFS_SS_BIT])
    else $error("slave select not taken from port 2 bit 4");

endmodule : ppfs_pin_mux

// File: verification/ppfs_board.sv
// Board and SPI peer model standing at the pads of the pin mux.
// Assumes pad vectors laid out port 1, then port 2, then port 3.
`timescale 1ns/10ps
module ppfs_board (
  // Clock
  input  wire logic        clk,
  // Device pad controls
  input  wire logic [17:0] pad_out,
  input  wire logic [17:0] pad_oe,
  input  wire logic [17:0] pad_pu,
  // Board and peer drive, slave select included
  input  wire logic [17:0] ext_val,
  input  wire logic [17:0] ext_en,
  // Resolved levels
  output logic [17:0]      pin_lvl
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  logic [17:0] last_r;

  // Floating pad shows inverse of last level, never a held value
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      if (pad_oe[i]) pin_lvl[i] = pad_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pad_pu[i]) pin_lvl[i] = 1'b1;
      else pin_lvl[i] = ~last_r[i];
    end
  end

  initial last_r = 18'h00000;
  always @(posedge clk) last_r <= pin_lvl;
endmodule : ppfs_board

// File: verification/tb_top.sv
// Self-checking bench for the pin mux, random stimulus plus corner cases.
// Assumes ppfs_board as pad model; all outputs one cycle after inputs.
`timescale 1ns/10ps
module tb_top;
  import ppfs_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rst, spi_enable, spi_master, spi_mosi_out, spi_miso_out, spi_sclk_out;
  ppfs_mode_t [7:0] port1_mode, port2_mode;
  ppfs_mode_t [1:0] port3_mode;
  logic [7:0] port1_latch, port2_latch, port1_pin_in, port2_pin_in, port1_out, port1_oe, port1_pu;
  logic [7:0] port2_out, port2_oe, port2_pu, port1_core_in, port2_core_in;
  logic [1:0] port3_latch, port3_pin_in, port3_out, port3_oe, port3_pu, port3_core_in;
  ppfs_clk_src_t cpu_clk_src;
  logic rtc_uses_crystal, crystal_option, clock_out_enable, spi_ss_n, osc_amp_connect, osc_in_connect;
  logic half_clock_active;
  logic [17:0] ext_val, ext_en, pins, p_out, p_oe, p_pu, snap;
  logic [127:0] rnd;
  integer seed;
  int failures, checks_done, n, s, c, j;
  typedef ppfs_mode_t [7:0] ppfs_mode8_t;
  typedef ppfs_mode_t [1:0] ppfs_mode2_t;

  assign p_out = {port3_out, port2_out, port1_out};
  assign p_oe  = {port3_oe, port2_oe, port1_oe};
  assign p_pu  = {port3_pu, port2_pu, port1_pu};
  assign {port3_pin_in, port2_pin_in, port1_pin_in} = pins;

  ppfs_pin_mux DUT (.clk, .rst, .port1_mode, .port2_mode, .port3_mode, .port1_latch, .port2_latch,
    .port3_latch, .spi_enable, .spi_master, .spi_mosi_out, .spi_miso_out, .spi_sclk_out, .cpu_clk_src,
    .rtc_uses_crystal, .crystal_option, .clock_out_enable, .port1_pin_in, .port2_pin_in, .port3_pin_in,
    .port1_out, .port1_oe, .port1_pu, .port2_out, .port2_oe, .port2_pu, .port3_out, .port3_oe, .port3_pu,
    .port1_core_in, .port2_core_in, .port3_core_in, .spi_ss_n, .osc_amp_connect, .osc_in_connect,
    .half_clock_active);

  ppfs_board board (.clk(clk), .pad_out(p_out), .pad_oe(p_oe), .pad_pu(p_pu), .ext_val(ext_val),
    .ext_en(ext_en), .pin_lvl(pins));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // Expected {out mask, out, oe, pu} per pin from current inputs
  function automatic void expect_all(output logic [17:0] mo, eo, ee, ep, mp);
    ppfs_mode_t  m;
    logic [17:0] lat;
    logic [3:0]  r;
    lat = {port3_latch, port2_latch, port1_latch};
    for (int i = 0; i < 18; i++) begin
      m = i < 8 ? port1_mode[i] : (i < 16 ? port2_mode[i-8] : port3_mode[i-16]);
      case (m)
        PPFS_QUASI_BIDIR: r = {1'b1, lat[i], ~lat[i], 1'b1};
        PPFS_PUSH_PULL:   r = {1'b1, lat[i], 2'b10};
        PPFS_INPUT_ONLY:  r = 4'h0;
        default:          r = {1'b1, lat[i], ~lat[i], 1'b0};
      endcase
      {mo[i], eo[i], ee[i], ep[i]} = r;
      mp[i] = 1'b1;
    end
    {mo[5], eo[5], ee[5], ep[5]} = 4'h8;
    if (spi_enable) begin
      {mo[10], eo[10], ee[10], ep[10]} = {1'b1, spi_mosi_out, spi_master, 1'b0};
      {mo[11], eo[11], ee[11], ep[11]} = {1'b1, spi_miso_out, ~spi_master, 1'b0};
      {mo[13], eo[13], ee[13], ep[13]} = {1'b1, spi_sclk_out, spi_master, 1'b0};
      if (!spi_master) {mo[12], ee[12], mp[12]} = 3'h0;
    end
    if (!(cpu_clk_src == PPFS_SRC_RC || cpu_clk_src == PPFS_SRC_WDT) || rtc_uses_crystal)
      {mo[17], eo[17], ee[17], ep[17]} = 4'h8;
    if (crystal_option) {mo[16], eo[16], ee[16], ep[16]} = 4'h8;
  endfunction : expect_all

  // Inputs were driven at the last edge; results show after the next
  task automatic cycle_check;
    logic [17:0] mo, eo, ee, ep, mp;
    logic        xin;
    @(negedge clk);
    snap = pins;
    @(posedge clk);
    @(negedge clk);
    expect_all(mo, eo, ee, ep, mp);
    xin = !(cpu_clk_src == PPFS_SRC_RC || cpu_clk_src == PPFS_SRC_WDT) || rtc_uses_crystal;
    check(p_out & mo, eo & mo);
    check(p_oe, ee);
    check(p_pu & mp, ep & mp);
    check({port3_core_in, port2_core_in, port1_core_in}, snap);
    check(spi_ss_n, (spi_enable && !spi_master) ? snap[12] : 1'b1);
    check({osc_amp_connect, osc_in_connect, half_clock_active}, {crystal_option, xin, 1'b0});
  endtask : cycle_check

  task automatic reset_check;
    @(posedge clk);
    rst <= 1'b1;
    repeat (7) begin
      @(posedge clk);
      rnd[31:0] = $random(seed);
      port2_mode <= ppfs_mode8_t'(rnd[15:0]);
      port3_mode <= ppfs_mode2_t'(rnd[19:16]);
      @(negedge clk);
      check(p_oe[17:8], 10'h000);
      check(p_pu[17:8], 10'h000);
      check({spi_ss_n, half_clock_active}, 2'b10);
    end
    // Release on a rising edge so the first sampled edge is clean
    @(posedge clk);
    rst <= 1'b0;
  endtask : reset_check

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 91808;
    rst = 1'b1;
    port1_mode = ppfs_mode8_t'(16'h0000);
    port2_mode = ppfs_mode8_t'(16'h0000);
    port3_mode = ppfs_mode2_t'(4'h0);
    {port1_latch, port2_latch, port3_latch} = '0;
    {spi_enable, spi_master, spi_mosi_out, spi_miso_out, spi_sclk_out} = 5'h00;
    cpu_clk_src = PPFS_SRC_RC;
    {rtc_uses_crystal, crystal_option, clock_out_enable} = 3'h0;
    ext_val = '0;
    ext_en = '0;
    reset_check();
    for (n = 0; n < 300; n++) begin
      if (n == 150) reset_check();
      @(posedge clk);
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      port1_mode <= ppfs_mode8_t'(rnd[15:0]);
      port2_mode <= ppfs_mode8_t'(rnd[31:16]);
      port3_mode <= ppfs_mode2_t'(rnd[35:32]);
      {port1_latch, port2_latch, port3_latch} <= rnd[53:36];
      spi_enable <= rnd[54];
      spi_master <= rnd[55];
      spi_mosi_out <= rnd[56];
      spi_miso_out <= rnd[57];
      spi_sclk_out <= rnd[58];
      cpu_clk_src <= ppfs_clk_src_t'(rnd[60:59]);
      rtc_uses_crystal <= rnd[61];
      crystal_option <= rnd[62];
      ext_val <= rnd[81:64];
      ext_en <= rnd[113:96];
      cycle_check();
    end
    // Divided clock enabled: every source against no block, the RTC crystal and the crystal option
    for (s = 0; s < 4; s++) begin
      for (c = 0; c < 3; c++) begin
        @(posedge clk);
        cpu_clk_src <= ppfs_clk_src_t'(s);
        rtc_uses_crystal <= (c == 1);
        crystal_option <= (c == 2);
        clock_out_enable <= 1'b1;
        port3_mode[0] <= PPFS_INPUT_ONLY;
        @(posedge clk);
        for (j = 0; j < 4; j++) begin
          @(negedge clk);
          if (s != 3 && c == 0) check({port3_out[0], port3_oe[0], half_clock_active}, {~j[0], 2'b11});
          else check({port3_oe[0], half_clock_active}, 2'b00);
          @(posedge clk);
        end
      end
    end
    tally_and_finish();
  end

  initial begin : watchdog
    #(20000 * 50);
    failures++;
    tally_and_finish();
  end
endmodule : tb_top
